// File: rtl/acc_defs.svh
// Register offsets, field positions, reset values and timing constants
// Assumes a plain register port with word indices and one 40 MHz clock
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_IDX_CTRL0 4'h0
`define ACC_IDX_CTRL1 4'h1
`define ACC_IDX_CTRL2 4'h2
`define ACC_IDX_STATUS 4'h3
`define ACC_IDX_IRQ_FLAGS 4'h4
`define ACC_IDX_IRQ_MASK 4'h5
`define ACC_BIT_ENABLE 15
`define ACC_BIT_PIN_DRIVE 14
`define ACC_BIT_INVERT 13
`define ACC_BIT_LEVEL 8
`define ACC_BIT_EDGE_HI 7
`define ACC_BIT_EDGE_LO 6
`define ACC_BIT_POS_SEL 4
`define ACC_BIT_NEG_HI 1
`define ACC_BIT_NEG_LO 0
`define ACC_BIT_STOP_IDLE 13
`define ACC_CTRL_WMASK 32'h0000_e0d3
`define ACC_CTRL_RESET 32'h0000_00c3
`define ACC_STATUS_WMASK 32'h0000_2000
`define ACC_SYNC_STAGES 3
`endif

// File: rtl/acc_pkg.sv
// Types shared by the comparator control logic
// Assumes the constants header is included alongside
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_EDGE_NONE,
      ACC_EDGE_RISE,
      ACC_EDGE_FALL,
      ACC_EDGE_BOTH
   } acc_edge_t;
   typedef enum logic [1:0] {
      ACC_NEG_PIN_B,
      ACC_NEG_PIN_C,
      ACC_NEG_PIN_D,
      ACC_NEG_ABS_REF
   } acc_neg_sel_t;
endpackage

// File: rtl/acc_top.sv
// Control and event logic for three analog comparators
// Assumes raw results arrive asynchronously from the analog cores
`include "acc_defs.svh"
module acc_top #(
   parameter int NUM_CMP = 3
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic idle_mode,
   input wire logic [NUM_CMP-1:0] raw_result,
   output logic [NUM_CMP-1:0] cmp_power_on,
   output logic [NUM_CMP-1:0] positive_input_select,
   output logic [2*NUM_CMP-1:0] negative_input_select,
   output logic [NUM_CMP-1:0] result_output_pin,
   output logic [NUM_CMP-1:0] result_output_pin_oe_n,
   output logic [NUM_CMP-1:0] cmp_event,
   output logic irq
);
   logic [31:0] ctrl_reg [NUM_CMP];
   logic [31:0] ctrl_next [NUM_CMP];
   logic stop_idle_reg, stop_idle_next;
   logic [NUM_CMP-1:0] flags_reg, flags_next;
   logic [NUM_CMP-1:0] mask_reg, mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [NUM_CMP-1:0] s1_reg, s2_reg, s3_reg;
   logic [NUM_CMP-1:0] lvl_reg, lvl_next;
   logic [NUM_CMP-1:0] evt_reg, evt_next;
   logic [NUM_CMP-1:0] pon_reg, pon_next;
   logic [NUM_CMP-1:0] pos_reg, pos_next;
   logic [2*NUM_CMP-1:0] neg_reg, neg_next;
   logic [NUM_CMP-1:0] pin_reg, pin_next;
   logic [NUM_CMP-1:0] oen_reg, oen_next;
   logic irq_reg, irq_next;
   logic [NUM_CMP-1:0] active;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= raw_result;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         active[i] = ctrl_reg[i][`ACC_BIT_ENABLE] &
                     ~(stop_idle_reg & idle_mode);
      end
   end

   always_comb begin
      lvl_next = lvl_reg;
      evt_next = '0;
      pon_next = active;
      for (int i = 0; i < NUM_CMP; i++) begin
         logic pol;
         logic lvl;
         acc_pkg::acc_edge_t edge_sel;
         pol = ctrl_reg[i][`ACC_BIT_INVERT];
         edge_sel = acc_pkg::acc_edge_t'(
            ctrl_reg[i][`ACC_BIT_EDGE_HI:`ACC_BIT_EDGE_LO]);
         lvl = 1'b0;
         // Level follows sync stages s2 and s3 only once they agree; an inactive comparator forces it low
         if (s2_reg[i] == s3_reg[i]) begin
            lvl = s3_reg[i] ^ pol;
         end else begin
            lvl = lvl_reg[i];
         end
         if (!active[i]) begin
            lvl = 1'b0;
         end
         lvl_next[i] = lvl;
         case (edge_sel)
            acc_pkg::ACC_EDGE_RISE: evt_next[i] = lvl & ~lvl_reg[i];
            acc_pkg::ACC_EDGE_FALL: evt_next[i] = ~lvl & lvl_reg[i];
            acc_pkg::ACC_EDGE_BOTH: evt_next[i] = lvl ^ lvl_reg[i];
            default: evt_next[i] = 1'b0;
         endcase
         if (!active[i]) begin
            evt_next[i] = 1'b0;
         end
         pos_next[i] = ctrl_reg[i][`ACC_BIT_POS_SEL];
         neg_next[2*i +: 2] =
            ctrl_reg[i][`ACC_BIT_NEG_HI:`ACC_BIT_NEG_LO];
         pin_next[i] = lvl & ctrl_reg[i][`ACC_BIT_PIN_DRIVE];
         oen_next[i] = ~(ctrl_reg[i][`ACC_BIT_PIN_DRIVE] & active[i]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lvl_reg <= '0;
         evt_reg <= '0;
         pon_reg <= '0;
         pos_reg <= '0;
         neg_reg <= '1;
         pin_reg <= '0;
         oen_reg <= '1;
      end else begin
         lvl_reg <= lvl_next;
         evt_reg <= evt_next;
         pon_reg <= pon_next;
         pos_reg <= pos_next;
         neg_reg <= neg_next;
         pin_reg <= pin_next;
         oen_reg <= oen_next;
      end
   end

   // Register file and interrupt logic
   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         ctrl_next[i] = ctrl_reg[i];
      end
      stop_idle_next = stop_idle_reg;
      mask_next = mask_reg;
      flags_next = flags_reg;
      rdata_next = '0;
      if (reg_wr) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (reg_addr == 4'(i)) begin
               ctrl_next[i] = reg_wdata & `ACC_CTRL_WMASK;
            end
         end
         case (reg_addr)
            `ACC_IDX_STATUS: stop_idle_next = reg_wdata[`ACC_BIT_STOP_IDLE];
            `ACC_IDX_IRQ_FLAGS: flags_next = flags_reg &
                                            ~reg_wdata[NUM_CMP-1:0];
            `ACC_IDX_IRQ_MASK: mask_next = reg_wdata[NUM_CMP-1:0];
            default: ;
         endcase
      end
      // Hardware set wins over software clear
      flags_next = flags_next | evt_reg;
      if (reg_rd) begin
         case (reg_addr)
            `ACC_IDX_CTRL0, `ACC_IDX_CTRL1, `ACC_IDX_CTRL2: begin
               rdata_next = ctrl_reg[reg_addr[1:0]];
               rdata_next[`ACC_BIT_LEVEL] = lvl_reg[reg_addr[1:0]];
            end
            `ACC_IDX_STATUS: begin
               rdata_next[`ACC_BIT_STOP_IDLE] = stop_idle_reg;
               rdata_next[NUM_CMP-1:0] = lvl_reg;
            end
            `ACC_IDX_IRQ_FLAGS: rdata_next[NUM_CMP-1:0] = flags_reg;
            `ACC_IDX_IRQ_MASK: rdata_next[NUM_CMP-1:0] = mask_reg;
            default: rdata_next = '0;
         endcase
      end
      irq_next = |(flags_next & mask_next);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            ctrl_reg[i] <= `ACC_CTRL_RESET;
         end
         stop_idle_reg <= 1'b0;
         mask_reg <= '0;
         flags_reg <= '0;
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            ctrl_reg[i] <= ctrl_next[i];
         end
         stop_idle_reg <= stop_idle_next;
         mask_reg <= mask_next;
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign cmp_power_on = pon_reg;
   assign positive_input_select = pos_reg;
   assign negative_input_select = neg_reg;
   assign result_output_pin = pin_reg;
   assign result_output_pin_oe_n = oen_reg;
   assign cmp_event = evt_reg;
   assign irq = irq_reg;
endmodule // acc_top

// File: sim/acc_top_properties.sv
// Port checker for the comparator control block
// Assumes one clock domain and the register map of the block's header
module acc_chk #(parameter int NUM_CMP = 3) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic idle_mode,
   input wire logic [NUM_CMP-1:0] raw_result,
   input wire logic [NUM_CMP-1:0] cmp_power_on,
   input wire logic [NUM_CMP-1:0] positive_input_select,
   input wire logic [2*NUM_CMP-1:0] negative_input_select,
   input wire logic [NUM_CMP-1:0] result_output_pin,
   input wire logic [NUM_CMP-1:0] result_output_pin_oe_n,
   input wire logic [NUM_CMP-1:0] cmp_event,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   ctrl_unused_a: assert property (
      $past(reg_rd && reg_addr <= 4'h2) |-> (reg_rdata & ~32'h0000_e1d3) == 0)
      else $error("control read shows unused bits");
   status_unused_a: assert property (
      $past(reg_rd && reg_addr == 4'h3) |-> (reg_rdata & ~32'h0000_2007) == 0)
      else $error("status read shows unused bits");
   unmapped_read_a: assert property ($past(reg_rd && reg_addr > 4'h5)
      |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
   event_single_a: assert property ((cmp_event & $past(cmp_event)) == 0)
      else $error("event longer than one cycle");
   pin_release_a: assert property (
      (result_output_pin & result_output_pin_oe_n) == 0)
      else $error("released pin carries a one");
   irq_rise_a: assert property ($rose(irq) |-> $past(|cmp_event)
      || $past(reg_wr && reg_addr == 4'h5)) else $error("irq without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr &&
      (reg_addr == 4'h4 || reg_addr == 4'h5))) else $error("irq dropped");
   select_change_a: assert property (
      !$stable({positive_input_select, negative_input_select}) |->
      $past(reg_wr && reg_addr <= 4'h2) || $past(reg_wr && reg_addr <= 4'h2, 2))
      else $error("input select moved without a write");
   cover property (cmp_event[1]);
   cover property ($rose(irq));
   cover property (idle_mode && cmp_power_on == 0);
endmodule // acc_chk
bind acc_top acc_chk #(.NUM_CMP(NUM_CMP)) chk_i (.sys_clk, .sys_rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .idle_mode,
   .raw_result, .cmp_power_on, .positive_input_select,
   .negative_input_select, .result_output_pin, .result_output_pin_oe_n,
   .cmp_event, .irq);

// File: sim/acc_cmp_model.sv
// Behavioural analog comparator cores
// Assumes the bench sets the ideal result level of each core
module acc_cmp_model (
   input wire logic sys_clk,
   input wire logic [2:0] cmp_power_on,
   input wire logic [2:0] analog_high,
   output logic [2:0] raw_result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip = 1'b0;
   // A core that is off gives no valid level
   always @(negedge sys_clk) flip <= ~flip;
   assign raw_result = (cmp_power_on & analog_high) |
      (~cmp_power_on & {3{flip}});
endmodule // acc_cmp_model

// File: sim/tb_top.sv
// Self-checking bench for the comparator control block
// Assumes the comparator model stands behind the raw result inputs
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic idle_mode = 1'b0, irq;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [2:0] analog_high = 3'h0, raw_result, cmp_power_on, cmp_event;
   logic [2:0] positive_input_select, result_output_pin;
   logic [2:0] result_output_pin_oe_n;
   logic [5:0] negative_input_select;
   int miscompares = 0, total_checks = 0, n_r, n_f;
   always #12.5 sys_clk = ~sys_clk;
   acc_top dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .idle_mode, .raw_result, .cmp_power_on,
      .positive_input_select, .negative_input_select, .result_output_pin,
      .result_output_pin_oe_n, .cmp_event, .irq);
   acc_cmp_model model (.sys_clk, .cmp_power_on, .analog_high, .raw_result);
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic cnt(input logic v, output int n);
      n = 0;
      analog_high[1] <= v;
      // Sample just after the edge so the pulse launched there is settled
      repeat (10) begin
         @(posedge sys_clk);
         #1 n += (cmp_event[1] === 1'b1);
      end
   endtask
   initial begin
      #1ms miscompares++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 3; i++) rd(i[3:0], 32'h0000_00c3);
      rd(4'hf, 32'h0);
      chk({negative_input_select, result_output_pin_oe_n}, 32'h1ff);
      $display("reset test done");
      wr(4'h0, 32'hffff_ffff);
      repeat (8) @(posedge sys_clk);
      rd(4'h0, 32'h0000_e1d3);
      chk({cmp_power_on, result_output_pin, result_output_pin_oe_n}, 9'h4e);
      wr(4'h3, 32'hffff_ffff);
      rd(4'h3, 32'h0000_2001);
      idle_mode <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk({cmp_power_on, result_output_pin_oe_n}, 6'h07);
      rd(4'h3, 32'h0000_2000);
      idle_mode <= 1'b0;
      wr(4'h3, 32'h0);
      wr(4'h0, 32'h0000_60d3);
      @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
      rd(4'h0, 32'h0000_60d3);
      chk(cmp_power_on, 3'h0);
      $display("control test done");
      for (int k = 0; k < 4; k++) begin
         wr(4'h2, 32'(k) | 32'(k[0]) << 4);
         repeat (2) @(posedge sys_clk);
         chk({positive_input_select[2], negative_input_select[5:4]},
            {k[0], k[1:0]});
      end
      for (int c = 0; c < 8; c++) begin
         wr(4'h1, 32'h8000 | 32'(c[2]) << 13 | 32'(c[1:0]) << 6);
         cnt(1'b0, n_r);
         cnt(1'b1, n_r);
         cnt(1'b0, n_f);
         chk(n_r, c[2] ? c[1] : c[0]);
         chk(n_f, c[2] ? c[0] : c[1]);
      end
      $display("edge test done");
      wr(4'h1, 32'h0000_8040);
      wr(4'h4, 32'h7);
      rd(4'h4, 32'h0);
      wr(4'h5, 32'h2);
      cnt(1'b1, n_r);
      rd(4'h4, 32'h2);
      chk(irq, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wr(i == 2 ? 4'h4 : 4'h5, i == 0 ? 32'h0 : 32'h2);
         repeat (2) @(posedge sys_clk);
         chk(irq, i == 1);
      end
      rd(4'h4, 32'h0);
      $display("interrupt test done");
      test_done();
   end
endmodule // tb_top
